// File: design/intc_core.sv
`timescale 1ns/10ps
`include "intc_consts.svh"

module intc_core (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic [`INTC_ADDR_W-1:0]  io_addr,
	input  wire logic                     io_wr,
	input  wire logic                     io_rd,
	input  wire logic [7:0]               io_wdata,
	output logic      [7:0]               io_rdata,
	input  wire logic [7:0]               request_lines,
	input  wire logic                     interrupt_acknowledge_cycle,
	output logic                          intr,
	output logic      [7:0]               vector_data,
	output logic                          vector_oe
);
	import intc_pkg::*;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [`INTC_SYNC_W-1:0] synced;
	logic [7:0]              req_sync;
	logic                    interrupt_acknowledge_cycle_sync;

	pin_sync u_sync (
		.clk    (clk),
		.rst    (rst),
		.pins   ({interrupt_acknowledge_cycle, request_lines}),
		.synced (synced)
	);

	assign req_sync  = synced[7:0];
	assign interrupt_acknowledge_cycle_sync = synced[8];

	ctrl_s st_r;
	ctrl_s st_nxt;

	// ****************************************************************
	// Priority resolution
	// ****************************************************************
	logic [7:0] svc_bits;
	logic [7:0] req_bits;
	pick_s      svc;
	pick_s      req;
	logic       grant_ok;

	// Under special mask, masked service bits neither block nor get ended by a nonspecific end
	assign svc_bits = st_r.smm ? (st_r.in_service_bits & ~st_r.channel_mask_bits)
	                           : st_r.in_service_bits;
	assign req_bits = st_r.pending_request_bits & ~st_r.channel_mask_bits;

	prio_pick u_svc_pick (
		.bits (svc_bits),
		.top  (st_r.top),
		.pick (svc)
	);

	prio_pick u_req_pick (
		.bits (req_bits),
		.top  (st_r.top),
		.pick (req)
	);

	// Only a strictly lower rank (higher priority) may nest over a channel in service
	assign grant_ok = req.found && (!svc.found || req.rank < svc.rank);

	// ****************************************************************
	// Decode
	// ****************************************************************
	logic       sel;
	logic       wr_even;
	logic       wr_odd;
	logic       rd_even;
	logic       rd_odd;
	logic       interrupt_acknowledge_cycle_rise;
	logic       interrupt_acknowledge_cycle_fall;
	logic [7:0] rise;
	logic [2:0] cmd;

	assign sel       = {io_addr[`INTC_ADDR_W-1:1], 1'b0} == `INTC_EVEN_ADDR;
	assign wr_even   = io_wr && sel && !io_addr[0];
	assign wr_odd    = io_wr && sel && io_addr[0];
	assign rd_even   = io_rd && sel && !io_addr[0];
	assign rd_odd    = io_rd && sel && io_addr[0];
	assign interrupt_acknowledge_cycle_rise = interrupt_acknowledge_cycle_sync && !st_r.interrupt_acknowledge_cycle_prev;
	assign interrupt_acknowledge_cycle_fall = !interrupt_acknowledge_cycle_sync && st_r.interrupt_acknowledge_cycle_prev;
	assign rise      = req_sync & ~st_r.req_prev;
	assign cmd       = io_wdata[7:5];

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		st_nxt           = st_r;
		st_nxt.req_prev  = req_sync;
		st_nxt.interrupt_acknowledge_cycle_prev = interrupt_acknowledge_cycle_sync;

		// Level mode follows the line; edge mode latches until taken
		if (st_r.level_mode) begin
			st_nxt.pending_request_bits = req_sync;
		end else begin
			st_nxt.pending_request_bits = st_r.pending_request_bits;
		end

		// Acknowledge sequence
		if (interrupt_acknowledge_cycle_rise && !st_r.ack_second) begin
			st_nxt.ack_second = 1'b1;
			st_nxt.spurious   = !grant_ok;
			if (grant_ok) begin
				st_nxt.ack_ch                        = req.ch;
				st_nxt.in_service_bits[req.ch]      = 1'b1;
				st_nxt.pending_request_bits[req.ch] = 1'b0;
			end else begin
				st_nxt.ack_ch = `INTC_SPURIOUS_CH;
			end
		end else if (interrupt_acknowledge_cycle_rise) begin
			st_nxt.vector    = {st_r.vec_base, st_r.ack_ch};
			st_nxt.vector_oe = 1'b1;
		end
		if (interrupt_acknowledge_cycle_fall && st_r.vector_oe) begin
			st_nxt.vector_oe  = 1'b0;
			st_nxt.ack_second = 1'b0;
			if (st_r.automatic_service_end && !st_r.spurious) begin
				st_nxt.in_service_bits[st_r.ack_ch] = 1'b0;
				if (st_r.auto_rot) begin
					st_nxt.top = 3'(st_r.ack_ch + 3'h1);
				end
			end
		end

		// Register writes
		if (wr_even && io_wdata[`INTC_INIT_BIT]) begin
			st_nxt.init_state        = INIT_WORD2;
			st_nxt.level_mode        = io_wdata[`INTC_LEVEL_BIT];
			st_nxt.top               = `INTC_TOP_RST;
			st_nxt.auto_rot          = 1'b0;
			st_nxt.smm               = 1'b0;
			st_nxt.read_isr          = 1'b0;
			st_nxt.slave_id          = `INTC_SLAVE_ID_RST;
			st_nxt.channel_mask_bits = 8'h00;
			st_nxt.pending_request_bits = 8'h00;
		end else if (wr_even) begin
			st_nxt.init_state = INIT_DONE;
			if (!io_wdata[`INTC_OCW_SEL_BIT]) begin
				case (cmd)
					`INTC_CMD_NS_END, `INTC_CMD_ROT_NS: begin
						if (svc.found) begin
							st_nxt.in_service_bits[svc.ch] = 1'b0;
							if (cmd == `INTC_CMD_ROT_NS || st_r.auto_rot) begin
								st_nxt.top = 3'(svc.ch + 3'h1);
							end
						end
					end
					`INTC_CMD_SP_END, `INTC_CMD_ROT_SP: begin
						st_nxt.in_service_bits[io_wdata[2:0]] = 1'b0;
						if (cmd == `INTC_CMD_ROT_SP || st_r.auto_rot) begin
							st_nxt.top = 3'(io_wdata[2:0] + 3'h1);
						end
					end
					`INTC_CMD_SET_TOP: begin
						st_nxt.top = io_wdata[2:0];
					end
					`INTC_CMD_AUTO_ON: begin
						st_nxt.auto_rot = 1'b1;
					end
					`INTC_CMD_AUTO_OFF: begin
						st_nxt.auto_rot = 1'b0;
					end
					default: begin
					end
				endcase
			end else begin
				if (io_wdata[`INTC_ESMM_BIT]) begin
					st_nxt.smm = io_wdata[`INTC_SMM_BIT];
				end
				if (io_wdata[`INTC_RR_BIT]) begin
					st_nxt.read_isr = io_wdata[`INTC_RIS_BIT];
				end
			end
		end else if (wr_odd) begin
			case (st_r.init_state)
				INIT_DONE: begin
					st_nxt.channel_mask_bits = io_wdata;
				end
				INIT_WORD2: begin
					st_nxt.vec_base   = io_wdata[7:3];
					st_nxt.init_state = INIT_WORD3;
				end
				INIT_WORD3: begin
					st_nxt.init_word_three = io_wdata;
					st_nxt.slave_id        = io_wdata[2:0];
					st_nxt.init_state      = INIT_WORD4;
				end
				INIT_WORD4: begin
					st_nxt.automatic_service_end = io_wdata[`INTC_AUTO_END_BIT];
					st_nxt.init_state            = INIT_DONE;
				end
				default: begin
					st_nxt.init_state = INIT_DONE;
				end
			endcase
		end

		// A request edge in the cycle its bit is taken is kept
		if (!st_r.level_mode) begin
			st_nxt.pending_request_bits = st_nxt.pending_request_bits | rise;
		end

		// Request is withheld while initialization is incomplete
		st_nxt.intr = grant_ok && st_r.init_state == INIT_DONE && !st_r.ack_second;

		if (rd_even) begin
			st_nxt.rdata = st_r.read_isr ? st_r.in_service_bits : st_r.pending_request_bits;
		end else if (rd_odd) begin
			st_nxt.rdata = st_r.channel_mask_bits;
		end else begin
			st_nxt.rdata = st_r.rdata;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r          <= '0;
			st_r.slave_id <= `INTC_SLAVE_ID_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign io_rdata    = st_r.rdata;
	assign intr        = st_r.intr;
	assign vector_data = st_r.vector;
	assign vector_oe   = st_r.vector_oe;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	logic operation_word_two_wr;
	assign operation_word_two_wr = wr_even && !io_wdata[`INTC_INIT_BIT] && !io_wdata[`INTC_OCW_SEL_BIT];

	property p_ns_end;
		operation_word_two_wr && cmd == `INTC_CMD_NS_END && svc.found && !interrupt_acknowledge_cycle_fall
		|=> !st_r.in_service_bits[$past(svc.ch)];
	endproperty
	a_ns_end: assert property (p_ns_end) else $error("nonspecific end left bit set");

	property p_sp_end;
		operation_word_two_wr && cmd == `INTC_CMD_SP_END
		|=> !st_r.in_service_bits[$past(io_wdata[2:0])];
	endproperty
	a_sp_end: assert property (p_sp_end) else $error("specific end left bit set");

	property p_smm_keep;
		operation_word_two_wr && cmd == `INTC_CMD_NS_END && st_r.smm && !interrupt_acknowledge_cycle_fall
		|=> ($past(st_r.in_service_bits & st_r.channel_mask_bits) & ~st_r.in_service_bits)
		    == 8'h00;
	endproperty
	a_smm_keep: assert property (p_smm_keep) else $error("masked service bit cleared");

	property p_auto_end;
		interrupt_acknowledge_cycle_fall && st_r.vector_oe && st_r.automatic_service_end && !st_r.spurious && !io_wr
		|=> !st_r.in_service_bits[$past(st_r.ack_ch)] && !vector_oe;
	endproperty
	a_auto_end: assert property (p_auto_end) else $error("automatic end missed");

	property p_init_start;
		wr_even && io_wdata[`INTC_INIT_BIT]
		|=> st_r.channel_mask_bits == 8'h00 && st_r.top == `INTC_TOP_RST && !st_r.smm
		    && !st_r.read_isr && st_r.slave_id == `INTC_SLAVE_ID_RST
		    && st_r.init_state == INIT_WORD2;
	endproperty
	a_init_start: assert property (p_init_start) else $error("init start effects wrong");

	property p_word_two;
		st_r.init_state == INIT_WORD2 && wr_odd
		|=> st_r.vec_base == $past(io_wdata[7:3]) && st_r.init_state == INIT_WORD3;
	endproperty
	a_word_two: assert property (p_word_two) else $error("second init word not taken");

	property p_init_abort;
		st_r.init_state != INIT_DONE && wr_even && !io_wdata[`INTC_INIT_BIT]
		|=> st_r.init_state == INIT_DONE;
	endproperty
	a_init_abort: assert property (p_init_abort) else $error("init not ended");

	property p_mask_load;
		st_r.init_state == INIT_DONE && wr_odd
		|=> st_r.channel_mask_bits == $past(io_wdata);
	endproperty
	a_mask_load: assert property (p_mask_load) else $error("mask word not loaded");

	property p_vector;
		$rose(vector_oe) |-> vector_data == {st_r.vec_base, st_r.ack_ch};
	endproperty
	a_vector: assert property (p_vector) else $error("vector byte wrong");

	property p_set_top;
		operation_word_two_wr && cmd == `INTC_CMD_SET_TOP
		|=> st_r.top == $past(io_wdata[2:0]);
	endproperty
	a_set_top: assert property (p_set_top) else $error("top channel not set");

	property p_nest_block;
		svc.found && req.found && req.rank >= svc.rank
		|=> !intr;
	endproperty
	a_nest_block: assert property (p_nest_block) else $error("lower request not blocked");

	// No rotation command can land while words two to four are awaited
	property p_fixed_order;
		st_r.init_state == INIT_WORD3
		|-> st_r.top == `INTC_TOP_RST && !st_r.auto_rot;
	endproperty
	a_fixed_order: assert property (p_fixed_order) else $error("priority not fixed");

	property p_auto_rot;
		interrupt_acknowledge_cycle_fall && st_r.vector_oe && st_r.automatic_service_end && !st_r.spurious
		&& st_r.auto_rot && !io_wr
		|=> st_r.top == 3'($past(st_r.ack_ch) + 3'h1);
	endproperty
	a_auto_rot: assert property (p_auto_rot) else $error("automatic rotation missed");

	property p_rot_cmd;
		operation_word_two_wr && cmd == `INTC_CMD_NS_END && st_r.auto_rot && svc.found && !interrupt_acknowledge_cycle_fall
		|=> st_r.top == 3'($past(svc.ch) + 3'h1);
	endproperty
	a_rot_cmd: assert property (p_rot_cmd) else $error("rotation on end missed");

	property p_pend_clear;
		interrupt_acknowledge_cycle_rise && !st_r.ack_second && grant_ok && !st_r.level_mode && !rise[req.ch]
		|=> !st_r.pending_request_bits[$past(req.ch)];
	endproperty
	a_pend_clear: assert property (p_pend_clear) else $error("pending bit kept");

	property p_intr_init;
		st_r.init_state != INIT_DONE
		|=> !intr;
	endproperty
	a_intr_init: assert property (p_intr_init) else $error("request during init");

	property p_first_ack;
		interrupt_acknowledge_cycle_rise && !st_r.ack_second && grant_ok && !io_wr
		|=> st_r.in_service_bits[$past(req.ch)] && st_r.ack_second;
	endproperty
	a_first_ack: assert property (p_first_ack) else $error("first acknowledge missed");
endmodule

// File: design/intc_consts.svh
// Function
// - Nonspecific end clears highest in-service channel
// - Specific end clears only the named channel
// - Special mask: masked service bits survive nonspecific end
// - Automatic end clears bit at second acknowledge end
// - After initialization channel zero highest, fixed
// - Fixed priority stays unless rotation is programmed
// - Acknowledge resolves, sets service bit, supplies vector
// - Service bit blocks equal and lower priorities
// - Specific rotation makes the named channel lowest priority
// - Auto rotation makes serviced channel lowest priority
// - Auto rotation applies on every end command
// - Auto rotation serves everyone within eight requests
// - Init start: fixed priority, no special mask
// - Init start clears the whole channel mask
// - Next three odd writes load words two-four
// - Even write bit four clear ends initialization
// - Odd write in operation loads channel mask
// - Bit three selects operation word two or three
// - First acknowledge sets service, clears pending bit
// - Vector is programmed high bits plus channel
`ifndef INTC_CONSTS_SVH
`define INTC_CONSTS_SVH

// ****************************************************************
// Port map (second controller of a pair would sit at 10'h0a0)
// ****************************************************************
`define INTC_ADDR_W        10
`define INTC_EVEN_ADDR     10'h020
`define INTC_ODD_ADDR      10'h021

// ****************************************************************
// Command word fields
// ****************************************************************
`define INTC_INIT_BIT      4
`define INTC_OCW_SEL_BIT   3
`define INTC_LEVEL_BIT     3
`define INTC_AUTO_END_BIT  1
`define INTC_ESMM_BIT      6
`define INTC_SMM_BIT       5
`define INTC_RR_BIT        1
`define INTC_RIS_BIT       0
`define INTC_CMD_NS_END    3'h1
`define INTC_CMD_NOP       3'h2
`define INTC_CMD_SP_END    3'h3
`define INTC_CMD_AUTO_OFF  3'h0
`define INTC_CMD_AUTO_ON   3'h4
`define INTC_CMD_ROT_NS    3'h5
`define INTC_CMD_SET_TOP   3'h6
`define INTC_CMD_ROT_SP    3'h7

// ****************************************************************
// Reset values and widths
// ****************************************************************
`define INTC_SLAVE_ID_RST  3'h7
`define INTC_SPURIOUS_CH   3'h7
`define INTC_TOP_RST       3'h0
`define INTC_SYNC_W        9

`endif

// File: design/intc_pkg.sv
package intc_pkg;

	typedef enum logic [1:0] {
		INIT_DONE  = 2'b00,
		INIT_WORD2 = 2'b01,
		INIT_WORD3 = 2'b10,
		INIT_WORD4 = 2'b11
	} init_state_e;

	typedef struct packed {
		logic       found;
		logic [2:0] ch;
		logic [2:0] rank;
	} pick_s;

	typedef struct packed {
		init_state_e init_state;
		logic [7:0]  pending_request_bits;
		logic [7:0]  in_service_bits;
		logic [7:0]  channel_mask_bits;
		logic [7:0]  req_prev;
		logic        level_mode;
		logic [4:0]  vec_base;
		logic [7:0]  init_word_three;
		logic [2:0]  slave_id;
		logic        automatic_service_end;
		logic [2:0]  top;
		logic        auto_rot;
		logic        smm;
		logic        read_isr;
		logic        interrupt_acknowledge_cycle_prev;
		logic        ack_second;
		logic [2:0]  ack_ch;
		logic        spurious;
		logic        intr;
		logic [7:0]  vector;
		logic        vector_oe;
		logic [7:0]  rdata;
	} ctrl_s;

endpackage

// File: design/pin_sync.sv
`timescale 1ns/10ps
`include "intc_consts.svh"

module pin_sync (
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic [`INTC_SYNC_W-1:0] pins,
	output logic      [`INTC_SYNC_W-1:0] synced
);
	typedef struct packed {
		logic [`INTC_SYNC_W-1:0] s1;
		logic [`INTC_SYNC_W-1:0] s2;
	} sync_s;

	sync_s st_r;
	sync_s st_nxt;

	// First stage feeds only the second stage
	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = pins;
		st_nxt.s2 = st_r.s1;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign synced = st_r.s2;
endmodule

// File: design/prio_pick.sv
`timescale 1ns/10ps

module prio_pick (
	input  wire logic         [7:0] bits,
	input  wire logic         [2:0] top,
	output intc_pkg::pick_s         pick
);
	import intc_pkg::*;

	// Rank 0 is the top channel; ranks grow in circular channel order
	always_comb begin
		logic [2:0] ch;
		ch   = 3'h0;
		pick = '0;
		for (int i = 7; i >= 0; i--) begin
			ch = 3'(top + 3'(i));
			if (bits[ch]) begin
				pick.found = 1'b1;
				pick.ch    = ch;
				pick.rank  = 3'(i);
			end
		end
	end
endmodule

// File: tb/host_model.sv
`timescale 1ns/10ps
`include "intc_consts.svh"

module host_model (
	input  wire logic                    clk,
	output logic      [`INTC_ADDR_W-1:0] io_addr,
	output logic                         io_wr,
	output logic                         io_rd,
	output logic      [7:0]              io_wdata,
	input  wire logic [7:0]              io_rdata,
	output logic                         interrupt_acknowledge_cycle,
	input  wire logic [7:0]              vector_data,
	input  wire logic                    vector_oe
);
	initial begin
		io_addr = 10'h000;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = 8'h00;
		interrupt_acknowledge_cycle = 1'b0;
	end

	// Released data bus shows the inverse so a stale byte never looks valid
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk);
		io_addr <= a;
		io_wdata <= d;
		io_wr <= 1'b1;
		@(posedge clk);
		io_wr <= 1'b0;
		io_wdata <= ~d;
	endtask

	task automatic rd(input logic [9:0] a, output logic [7:0] d);
		@(posedge clk);
		io_addr <= a;
		io_rd <= 1'b1;
		@(posedge clk);
		io_rd <= 1'b0;
		@(posedge clk);
		#1;
		d = io_rdata;
	endtask

	// Two pulses, six cycles each way, to clear the pin synchroniser
	task automatic ack(output logic [7:0] v);
		@(posedge clk);
		interrupt_acknowledge_cycle <= 1'b1;
		repeat (6) @(posedge clk);
		interrupt_acknowledge_cycle <= 1'b0;
		repeat (6) @(posedge clk);
		interrupt_acknowledge_cycle <= 1'b1;
		repeat (5) @(posedge clk);
		#1;
		v = (vector_oe === 1'b1) ? vector_data : 8'hee;
		@(posedge clk);
		interrupt_acknowledge_cycle <= 1'b0;
		repeat (6) @(posedge clk);
	endtask
endmodule

// File: tb/tb_top.sv
`timescale 1ns/10ps

module tb_top;
	logic       clk;
	logic       rst;
	logic [7:0] request_lines;
	logic [9:0] io_addr;
	logic       io_wr;
	logic       io_rd;
	logic [7:0] io_wdata;
	logic [7:0] io_rdata;
	logic       ack_pin;
	logic       intr;
	logic [7:0] vector_data;
	logic       vector_oe;
	int         fail_count;
	int         comparisons;

	intc_core u_dut (
		.clk                         (clk),
		.rst                         (rst),
		.io_addr                     (io_addr),
		.io_wr                       (io_wr),
		.io_rd                       (io_rd),
		.io_wdata                    (io_wdata),
		.io_rdata                    (io_rdata),
		.request_lines               (request_lines),
		.interrupt_acknowledge_cycle (ack_pin),
		.intr                        (intr),
		.vector_data                 (vector_data),
		.vector_oe                   (vector_oe)
	);

	host_model u_host (
		.clk                         (clk),
		.io_addr                     (io_addr),
		.io_wr                       (io_wr),
		.io_rd                       (io_rd),
		.io_wdata                    (io_wdata),
		.io_rdata                    (io_rdata),
		.interrupt_acknowledge_cycle (ack_pin),
		.vector_data                 (vector_data),
		.vector_oe                   (vector_oe)
	);

	always #25 clk = ~clk;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic close_out;
		$display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic req(input logic [7:0] m);
		@(posedge clk);
		request_lines <= m;
		repeat (3) @(posedge clk);
		request_lines <= 8'h00;
	endtask

	task automatic init4(input logic [7:0] w4);
		u_host.wr(10'h020, 8'h11);
		u_host.wr(10'h021, 8'h40);
		u_host.wr(10'h021, 8'h00);
		u_host.wr(10'h021, w4);
	endtask

	task automatic ack_chk(input logic [7:0] e);
		logic [7:0] g;
		u_host.ack(g);
		chk(g, e);
	endtask

	task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
		logic [7:0] g;
		u_host.rd(a, g);
		chk(g, e);
	endtask

	task automatic isr_chk(input logic [7:0] e);
		u_host.wr(10'h020, 8'h0b);
		rd_chk(10'h020, e);
	endtask

	task automatic intr_chk(input logic e);
		repeat (8) @(posedge clk);
		#1;
		chk({7'h00, intr}, {7'h00, e});
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_init;
		u_host.wr(10'h020, 8'h11);
		u_host.wr(10'h021, 8'h48);
		u_host.wr(10'h020, 8'h0a);
		u_host.wr(10'h021, 8'haa);
		rd_chk(10'h021, 8'haa);
		u_host.wr(10'h022, 8'h55);
		rd_chk(10'h021, 8'haa);
		init4(8'h00);
		rd_chk(10'h021, 8'h00);
		rd_chk(10'h020, 8'h00);
	endtask

	task automatic t_nested;
		req(8'h28);
		intr_chk(1'b1);
		ack_chk(8'h43);
		isr_chk(8'h08);
		intr_chk(1'b0);
		req(8'h02);
		intr_chk(1'b1);
		ack_chk(8'h41);
		isr_chk(8'h0a);
		u_host.wr(10'h020, 8'h20);
		isr_chk(8'h08);
		u_host.wr(10'h020, 8'h63);
		isr_chk(8'h00);
		ack_chk(8'h45);
		u_host.wr(10'h020, 8'h65);
	endtask

	task automatic t_rotate;
		u_host.wr(10'h020, 8'hc5);
		req(8'h50);
		ack_chk(8'h46);
		u_host.wr(10'h020, 8'h66);
		ack_chk(8'h44);
		u_host.wr(10'h020, 8'h64);
		u_host.wr(10'h020, 8'hc0);
	endtask

	task automatic t_smask;
		req(8'h04);
		ack_chk(8'h42);
		u_host.wr(10'h021, 8'h04);
		u_host.wr(10'h020, 8'h68);
		u_host.wr(10'h020, 8'h20);
		isr_chk(8'h04);
		u_host.wr(10'h020, 8'h62);
		isr_chk(8'h00);
	endtask

	task automatic t_auto;
		init4(8'h02);
		rd_chk(10'h021, 8'h00);
		u_host.wr(10'h020, 8'h80);
		req(8'h03);
		ack_chk(8'h40);
		isr_chk(8'h00);
		req(8'h01);
		ack_chk(8'h41);
		ack_chk(8'h40);
	endtask

	// Commanded rotation, rotation off, spurious vector, request held off in init
	task automatic t_rotend;
		u_host.wr(10'h020, 8'h11);
		req(8'h01);
		intr_chk(1'b0);
		u_host.wr(10'h021, 8'h40);
		u_host.wr(10'h021, 8'h00);
		u_host.wr(10'h021, 8'h00);
		intr_chk(1'b1);
		u_host.wr(10'h020, 8'h80);
		req(8'h02);
		ack_chk(8'h40);
		u_host.wr(10'h020, 8'h20);
		req(8'h01);
		ack_chk(8'h41);
		u_host.wr(10'h020, 8'h00);
		u_host.wr(10'h020, 8'ha0);
		req(8'h02);
		ack_chk(8'h40);
		isr_chk(8'h01);
		u_host.wr(10'h020, 8'h60);
		req(8'h01);
		ack_chk(8'h40);
		u_host.wr(10'h021, 8'hff);
		ack_chk(8'h47);
		isr_chk(8'h01);
		u_host.wr(10'h021, 8'h00);
		u_host.wr(10'h020, 8'he0);
		isr_chk(8'h00);
	endtask

	// ****************************************************************
	// Main sequence and watchdog
	// ****************************************************************
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		request_lines = 8'h00;
		fail_count = 0;
		comparisons = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		t_init;
		t_nested;
		t_rotate;
		t_smask;
		t_auto;
		t_rotend;
		close_out;
	end

	// Whole run is about six hundred cycles; this margin only cuts a hang
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		close_out;
	end
endmodule
